// ==== serial_port_pkg.sv ====
// constants for the four-mode serial port
package serial_port_pkg;
   localparam logic [11:0] ADDR_BUFFER = 12'h000;
   localparam logic [11:0] ADDR_CONTROL = 12'h004;
   localparam logic [11:0] ADDR_RELOAD = 12'h008;
   localparam logic [11:0] ADDR_TIMER = 12'h00C;
   localparam int CTL_RX_DONE = 0;
   localparam int CTL_TX_DONE = 1;
   localparam int CTL_RX_NINTH = 2;
   localparam int CTL_TX_NINTH = 3;
   localparam int CTL_RX_ENABLE = 4;
   localparam int CTL_QUALIFY = 5;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_SPEED0 = 8;
   localparam int CTL_DOUBLE = 9;
   localparam int CTL_TMR_IRQ_EN = 10;
   localparam int CTL_TMR_IRQ = 11;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam int MODE0_DIV_SLOW = 12;
   localparam int MODE0_DIV_FAST = 2;
   localparam int MODE2_TICK_SLOW = 4;
   localparam int MODE2_TICK_FAST = 2;
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_ASYNC8 = 2'h1;
   localparam logic [1:0] MODE_FIXED9 = 2'h2;
   localparam logic [1:0] MODE_TIMER9 = 2'h3;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_START = 2'b01, ST_DATA = 2'b11,
      ST_STOP = 2'b10} line_state_e;
   function automatic logic vote3(input logic a, input logic b, input logic c);
      return (a & b) | (a & c) | (b & c);
   endfunction : vote3
endpackage : serial_port_pkg

// ==== baud_timer.sv ====
// reloading baud-rate timer
`timescale 1ns/1ns
module baud_timer
   import serial_port_pkg::*;
#(
   parameter int PRESCALE = 1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] reload,
   output logic [15:0] count,
   output logic overflow
);
   logic [15:0] count_reg, count_next;
   logic [7:0] pre_reg, pre_next;
   logic ovf_reg, ovf_next;
   always_comb
   begin
      pre_next = pre_reg;
      count_next = count_reg;
      ovf_next = 1'b0;
      if (pre_reg >= 8'(PRESCALE - 1))
      begin
         pre_next = 8'h00;
         if (count_reg == 16'hFFFF)
         begin
            count_next = reload;
            ovf_next = 1'b1;
         end
         else
            count_next = count_reg + 16'h0001;
      end
      else
         pre_next = pre_reg + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_reg <= 8'h00;
         count_reg <= 16'h0000;
         ovf_reg <= 1'b0;
      end
      else
      begin
         pre_reg <= pre_next;
         count_reg <= count_next;
         ovf_reg <= ovf_next;
      end
   end
   assign count = count_reg;
   assign overflow = ovf_reg;
endmodule : baud_timer

// ==== async_receiver.sv ====
// oversampling asynchronous receiver
`timescale 1ns/1ns
module async_receiver
   import serial_port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic tick16,
   input wire logic nine_bit,
   input wire logic rxd,
   output logic frame_valid,
   output logic [8:0] frame_bits,
   output logic stop_bit
);
   line_state_e state_reg, state_next;
   logic [3:0] phase_reg, phase_next;
   logic [3:0] nbits_reg, nbits_next;
   logic [8:0] shift_reg, shift_next;
   logic [2:0] samp_reg, samp_next;
   logic rxd_prev_reg;
   logic valid_reg, valid_next;
   logic stop_reg, stop_next;
   logic bit_val;
   always_comb
   begin
      state_next = state_reg;
      phase_next = phase_reg;
      nbits_next = nbits_reg;
      shift_next = shift_reg;
      samp_next = samp_reg;
      valid_next = 1'b0;
      stop_next = stop_reg;
      bit_val = vote3(samp_reg[0], samp_reg[1], samp_reg[2]);
      if (!enable)
         state_next = ST_IDLE;
      else if (state_reg == ST_IDLE)
      begin
         if (rxd_prev_reg && !rxd)
         begin
            state_next = ST_START;
            phase_next = 4'h0;
         end
      end
      else if (tick16)
      begin
         phase_next = phase_reg + 4'h1;
         if (phase_reg == SAMPLE_A)
            samp_next[0] = rxd;
         if (phase_reg == SAMPLE_B)
            samp_next[1] = rxd;
         if (phase_reg == SAMPLE_C)
            samp_next[2] = rxd;
         if (phase_reg == 4'hF)
         begin
            case (state_reg)
               ST_START:
               begin
                  nbits_next = 4'h0;
                  state_next = bit_val ? ST_IDLE : ST_DATA;
               end
               ST_DATA:
               begin
                  shift_next = {bit_val, shift_reg[8:1]};
                  nbits_next = nbits_reg + 4'h1;
                  if (nbits_reg == (nine_bit ? 4'h8 : 4'h7))
                     state_next = ST_STOP;
               end
               ST_STOP:
               begin
                  stop_next = bit_val;
                  valid_next = 1'b1;
                  state_next = ST_IDLE;
               end
               default: state_next = ST_IDLE;
            endcase
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         phase_reg <= 4'h0;
         nbits_reg <= 4'h0;
         shift_reg <= 9'h000;
         samp_reg <= 3'h7;
         rxd_prev_reg <= 1'b1;
         valid_reg <= 1'b0;
         stop_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         nbits_reg <= nbits_next;
         shift_reg <= shift_next;
         samp_reg <= samp_next;
         rxd_prev_reg <= rxd;
         valid_reg <= valid_next;
         stop_reg <= stop_next;
      end
   end
   // 8-bit frames end up one place high; realign here
   assign frame_bits = nine_bit ? shift_reg : {1'b0, shift_reg[8:1]};
   assign frame_valid = valid_reg;
   assign stop_bit = stop_reg;
endmodule : async_receiver

// ==== four_mode_serial_port.sv ====
// four-mode serial port with apb registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module four_mode_serial_port
   import serial_port_pkg::*;
#(
   parameter int TIMER_PRESCALE = 1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic data_in,
   output logic data_out,
   output logic data_oe,
   output logic shift_clk_out,
   output logic timer_irq
);
   logic [7:0] buffer_reg, buffer_next;
   logic rx_done_reg, rx_done_next;
   logic tx_done_reg, tx_done_next;
   logic rx_ninth_reg, rx_ninth_next;
   logic tx_ninth_reg, tx_ninth_next;
   logic rx_en_reg, rx_en_next;
   logic qualify_reg, qualify_next;
   logic [1:0] mode_reg, mode_next;
   logic speed0_reg, speed0_next;
   logic double_reg, double_next;
   logic tirq_en_reg, tirq_en_next;
   logic tirq_reg, tirq_next;
   logic [15:0] reload_reg, reload_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   line_state_e tx_state_reg, tx_state_next;
   logic [9:0] tx_shift_reg, tx_shift_next;
   logic [3:0] tx_count_reg, tx_count_next;
   logic tx_pending_reg, tx_pending_next;
   logic [3:0] div16_reg, div16_next;
   logic [4:0] pre_reg, pre_next;
   logic tick16_reg, tick16_next;
   logic [3:0] sdiv_reg, sdiv_next;
   logic sclk_reg, sclk_next;
   logic m0_rx_reg, m0_rx_next;
   logic [7:0] m0_shift_reg, m0_shift_next;
   logic dout_reg, dout_next;
   logic doe_reg, doe_next;
   logic [15:0] tmr_count;
   logic tmr_ovf;
   logic rx_valid;
   logic [8:0] rx_bits;
   logic rx_stop;
   logic wr_access, rd_access, buf_write;
   logic async_mode, sclk_fall, sclk_rise;
   logic [3:0] sdiv_half;
   logic [31:0] ctl_word;

   baud_timer #(
      .PRESCALE(TIMER_PRESCALE)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .reload(reload_reg),
      .count(tmr_count),
      .overflow(tmr_ovf)
   );

   async_receiver u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .enable(rx_en_reg && async_mode),
      .tick16(tick16_reg),
      .nine_bit(mode_reg[1]),
      .rxd(data_in),
      .frame_valid(rx_valid),
      .frame_bits(rx_bits),
      .stop_bit(rx_stop)
   );

   assign async_mode = (mode_reg != MODE_SYNC);
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign buf_write = wr_access && (paddr == ADDR_BUFFER);
   assign sdiv_half = speed0_reg ? 4'(MODE0_DIV_FAST / 2 - 1) : 4'(MODE0_DIV_SLOW / 2 - 1);
   assign sclk_fall = !m0_idle() && sclk_reg && (sdiv_reg == sdiv_half);
   assign sclk_rise = !m0_idle() && !sclk_reg && (sdiv_reg == sdiv_half);
   assign ctl_word = {20'h00000, tirq_reg, tirq_en_reg, double_reg, speed0_reg, mode_reg,
      qualify_reg, rx_en_reg, tx_ninth_reg, rx_ninth_reg, tx_done_reg, rx_done_reg};

   function automatic logic m0_idle();
      return (tx_state_reg == ST_IDLE) && !m0_rx_reg;
   endfunction : m0_idle

   // oversample tick: timer overflow in modes 1/3, pclk/4 or /2 in mode 2
   always_comb
   begin
      pre_next = pre_reg + 5'h01;
      tick16_next = 1'b0;
      if (mode_reg == MODE_FIXED9)
      begin
         if (pre_reg >= (double_reg ? 5'(MODE2_TICK_FAST - 1) : 5'(MODE2_TICK_SLOW - 1)))
         begin
            pre_next = 5'h00;
            tick16_next = 1'b1;
         end
      end
      else
      begin
         pre_next = 5'h00;
         tick16_next = tmr_ovf;
      end
      div16_next = tick16_reg ? div16_reg + 4'h1 : div16_reg;
   end

   // registers and apb slave
   always_comb
   begin
      buffer_next = buffer_reg;
      rx_done_next = rx_done_reg;
      tx_done_next = tx_done_reg;
      rx_ninth_next = rx_ninth_reg;
      tx_ninth_next = tx_ninth_reg;
      rx_en_next = rx_en_reg;
      qualify_next = qualify_reg;
      mode_next = mode_reg;
      speed0_next = speed0_reg;
      double_next = double_reg;
      tirq_en_next = tirq_en_reg;
      tirq_next = tirq_reg;
      reload_next = reload_reg;
      prdata_next = 32'h00000000;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (psel && !penable)
      begin
         pready_next = 1'b1;
         pslverr_next = !(paddr == ADDR_BUFFER || paddr == ADDR_CONTROL ||
            paddr == ADDR_RELOAD || paddr == ADDR_TIMER);
      end
      if (rd_access)
      begin
         case (paddr)
            ADDR_BUFFER: prdata_next = {24'h000000, buffer_reg};
            ADDR_CONTROL: prdata_next = ctl_word;
            ADDR_RELOAD: prdata_next = {16'h0000, reload_reg};
            ADDR_TIMER: prdata_next = {16'h0000, tmr_count};
            default: prdata_next = 32'h00000000;
         endcase
      end
      if (wr_access && paddr == ADDR_CONTROL)
      begin
         rx_done_next = pwdata[CTL_RX_DONE];
         tx_done_next = pwdata[CTL_TX_DONE];
         rx_ninth_next = pwdata[CTL_RX_NINTH];
         tx_ninth_next = pwdata[CTL_TX_NINTH];
         rx_en_next = pwdata[CTL_RX_ENABLE];
         qualify_next = pwdata[CTL_QUALIFY];
         mode_next = pwdata[CTL_MODE_LO +: 2];
         speed0_next = pwdata[CTL_SPEED0];
         double_next = pwdata[CTL_DOUBLE];
         tirq_en_next = pwdata[CTL_TMR_IRQ_EN];
         tirq_next = pwdata[CTL_TMR_IRQ];
      end
      if (wr_access && paddr == ADDR_RELOAD)
         reload_next = pwdata[15:0];
      if (tmr_ovf)
         tirq_next = 1'b1;
      // hardware sets win over a same-cycle software clear
      if (tx_state_reg == ST_DATA && !async_mode && tx_count_reg == 4'h8 && sclk_rise)
         tx_done_next = 1'b1;
      if (async_mode && tx_state_reg == ST_DATA && tick16_reg && div16_reg == 4'hF
         && tx_count_reg == (mode_reg[1] ? 4'h8 : 4'h7))
         tx_done_next = 1'b1;
      if (m0_rx_reg && sclk_rise && m0_shift_next_done())
      begin
         buffer_next = {data_in, m0_shift_reg[7:1]};
         rx_done_next = 1'b1;
      end
      if (rx_valid && !rx_done_reg)
      begin
         if (!mode_reg[1] && (!qualify_reg || rx_stop))
         begin
            buffer_next = rx_bits[7:0];
            rx_ninth_next = rx_stop;
            rx_done_next = 1'b1;
         end
         else if (mode_reg[1] && (!qualify_reg || rx_bits[8]))
         begin
            buffer_next = rx_bits[7:0];
            rx_ninth_next = rx_bits[8];
            rx_done_next = 1'b1;
         end
      end
   end

   function automatic logic m0_shift_next_done();
      return tx_count_reg == 4'h7;
   endfunction : m0_shift_next_done

   // transmitter and mode 0 shift engine
   always_comb
   begin
      tx_state_next = tx_state_reg;
      tx_shift_next = tx_shift_reg;
      tx_count_next = tx_count_reg;
      tx_pending_next = tx_pending_reg;
      m0_rx_next = m0_rx_reg;
      m0_shift_next = m0_shift_reg;
      sdiv_next = m0_idle() ? 4'h0 : sdiv_reg + 4'h1;
      sclk_next = sclk_reg;
      dout_next = async_mode ? 1'b1 : dout_reg;
      doe_next = async_mode ? 1'b1 : doe_reg;
      if (!m0_idle() && sdiv_reg == sdiv_half)
      begin
         sdiv_next = 4'h0;
         sclk_next = !sclk_reg;
      end
      if (buf_write)
      begin
         tx_shift_next = {1'b1, tx_ninth_reg, pwdata[7:0]};
         tx_count_next = 4'h0;
         if (async_mode)
            tx_pending_next = 1'b1;
         else
         begin
            tx_state_next = ST_DATA;
            m0_rx_next = 1'b0;
            sclk_next = 1'b1;
            sdiv_next = 4'h0;
         end
      end
      else if (!async_mode)
      begin
         if (tx_state_reg == ST_IDLE && !m0_rx_reg && rx_en_reg && !rx_done_reg)
         begin
            m0_rx_next = 1'b1;
            tx_count_next = 4'h0;
            sclk_next = 1'b1;
            doe_next = 1'b0;
         end
         if (tx_state_reg == ST_DATA)
         begin
            doe_next = 1'b1;
            if (tx_count_reg == 4'h8 && sclk_rise)
            begin
               tx_state_next = ST_IDLE;
               sclk_next = 1'b1;
            end
            else if (sclk_fall)
            begin
               dout_next = tx_shift_reg[0];
               tx_shift_next = {1'b0, tx_shift_reg[9:1]};
               tx_count_next = tx_count_reg + 4'h1;
            end
         end
         if (m0_rx_reg && sclk_rise)
         begin
            m0_shift_next = {data_in, m0_shift_reg[7:1]};
            tx_count_next = tx_count_reg + 4'h1;
            if (tx_count_reg == 4'h7)
            begin
               m0_rx_next = 1'b0;
               sclk_next = 1'b1;
            end
         end
         if (tx_state_reg != ST_IDLE && tx_state_reg != ST_DATA)
            tx_state_next = ST_IDLE;
      end
      else
      begin
         m0_rx_next = 1'b0;
         sclk_next = 1'b1;
         if (tick16_reg && div16_reg == 4'hF)
         begin
            case (tx_state_reg)
               ST_IDLE:
                  if (tx_pending_reg)
                  begin
                     tx_pending_next = 1'b0;
                     tx_state_next = ST_START;
                  end
               ST_START:
               begin
                  tx_state_next = ST_DATA;
                  tx_count_next = 4'h0;
               end
               ST_DATA:
               begin
                  tx_shift_next = {1'b1, tx_shift_reg[9:1]};
                  tx_count_next = tx_count_reg + 4'h1;
                  if (tx_count_reg == (mode_reg[1] ? 4'h9 : 4'h8))
                     tx_state_next = ST_STOP;
               end
               ST_STOP: tx_state_next = ST_IDLE;
               default: tx_state_next = ST_IDLE;
            endcase
         end
         case (tx_state_reg)
            ST_START: dout_next = 1'b0;
            ST_DATA: dout_next = (tx_count_reg == (mode_reg[1] ? 4'h9 : 4'h8)) ?
               1'b1 : tx_shift_reg[0];
            default: dout_next = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         buffer_reg <= 8'h00;
         rx_done_reg <= 1'b0;
         tx_done_reg <= 1'b0;
         rx_ninth_reg <= 1'b0;
         tx_ninth_reg <= 1'b0;
         rx_en_reg <= 1'b0;
         qualify_reg <= 1'b0;
         mode_reg <= MODE_SYNC;
         speed0_reg <= 1'b0;
         double_reg <= 1'b0;
         tirq_en_reg <= 1'b0;
         tirq_reg <= 1'b0;
         reload_reg <= RELOAD_RESET;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         tx_state_reg <= ST_IDLE;
         tx_shift_reg <= 10'h3FF;
         tx_count_reg <= 4'h0;
         tx_pending_reg <= 1'b0;
         div16_reg <= 4'h0;
         pre_reg <= 5'h00;
         tick16_reg <= 1'b0;
         sdiv_reg <= 4'h0;
         sclk_reg <= 1'b1;
         m0_rx_reg <= 1'b0;
         m0_shift_reg <= 8'h00;
         dout_reg <= 1'b1;
         doe_reg <= 1'b1;
      end
      else
      begin
         buffer_reg <= buffer_next;
         rx_done_reg <= rx_done_next;
         tx_done_reg <= tx_done_next;
         rx_ninth_reg <= rx_ninth_next;
         tx_ninth_reg <= tx_ninth_next;
         rx_en_reg <= rx_en_next;
         qualify_reg <= qualify_next;
         mode_reg <= mode_next;
         speed0_reg <= speed0_next;
         double_reg <= double_next;
         tirq_en_reg <= tirq_en_next;
         tirq_reg <= tirq_next;
         reload_reg <= reload_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         tx_state_reg <= tx_state_next;
         tx_shift_reg <= tx_shift_next;
         tx_count_reg <= tx_count_next;
         tx_pending_reg <= tx_pending_next;
         div16_reg <= div16_next;
         pre_reg <= pre_next;
         tick16_reg <= tick16_next;
         sdiv_reg <= sdiv_next;
         sclk_reg <= sclk_next;
         m0_rx_reg <= m0_rx_next;
         m0_shift_reg <= m0_shift_next;
         dout_reg <= dout_next;
         doe_reg <= doe_next;
      end
   end

   // irq flag and mask registered together, in the same cycle as the flag
   logic irq_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= tirq_next && tirq_en_next;
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign data_out = dout_reg;
   assign data_oe = doe_reg;
   assign shift_clk_out = sclk_reg;
   assign timer_irq = irq_reg;
endmodule : four_mode_serial_port

// ==== four_mode_serial_port_monitor.sv ====
// port-level assertion checker for the four-mode serial port
`timescale 1ns/1ns
module four_mode_serial_port_monitor
   import serial_port_pkg::*;
#(
   parameter int TIMER_PRESCALE = 1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic data_in,
   input wire logic data_out,
   input wire logic data_oe,
   input wire logic shift_clk_out,
   input wire logic timer_irq
);
   logic [11:0] ctl_reg;
   // shadow of the control word, as last written over the bus
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_reg <= 12'h000;
      else if (psel && penable && pwrite && pready && paddr == ADDR_CONTROL)
         ctl_reg <= pwdata[11:0];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_reset_idle: assert property ($rose(presetn) |-> data_out && data_oe && shift_clk_out
      && !timer_irq) else $error("outputs not idle after reset");
   chk_ready_access: assert property (psel && !penable |=> pready)
      else $error("no answer in access cycle");
   chk_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
   chk_unmapped_err: assert property (psel && penable && pready && paddr > ADDR_TIMER
      |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   chk_sync_clk_rate: assert property (ctl_reg[7:6] == MODE_SYNC && !ctl_reg[CTL_SPEED0]
      && $rose(shift_clk_out) |=> (!$rose(shift_clk_out))[*8]) else $error("shift clock fast");
   chk_fixed_bit_hold: assert property (ctl_reg[7:6] == MODE_FIXED9 && !ctl_reg[CTL_DOUBLE]
      && $changed(data_out) |=> $stable(data_out)[*8]) else $error("bit too short");
   chk_async_oe: assert property (ctl_reg[7:6] != MODE_SYNC && $past(ctl_reg[7:6]) != MODE_SYNC
      |-> data_oe) else $error("data pin released in async mode");
   chk_irq_mask: assert property (!ctl_reg[CTL_TMR_IRQ_EN] && !$past(ctl_reg[CTL_TMR_IRQ_EN])
      |-> !timer_irq) else $error("masked timer interrupt seen");
endmodule : four_mode_serial_port_monitor

bind four_mode_serial_port four_mode_serial_port_monitor #(.TIMER_PRESCALE(TIMER_PRESCALE)) mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .shift_clk_out(shift_clk_out),
   .timer_irq(timer_irq));

// ==== serial_peer_model.sv ====
// far-side serial peer: async sender and mode 0 shift device
`timescale 1ns/1ns
module serial_peer_model
(
   input wire logic pclk,
   input wire logic sclk,
   output logic line
);
   logic [7:0] sync_reg = 8'hFF;
   logic sclk_prev = 1'b1;
   int cnt = 0;
   initial line = 1'b1;
   // frame bits lsb first; line back to idle high afterwards
   task automatic send(input logic [10:0] frm, input int n, input int per);
      for (int i = 0; i < n; i++)
      begin
         line <= frm[i];
         repeat (per) @(posedge pclk);
      end
      line <= 1'b1;
   endtask : send
   task automatic load(input logic [7:0] b);
      sync_reg = b;
      cnt = 8;
   endtask : load
   // next bit after each falling shift clock, released once 8 are out
   always @(posedge pclk)
   begin
      if (sclk_prev && !sclk && cnt > 0)
      begin
         line <= sync_reg[0];
         sync_reg = sync_reg >> 1;
         cnt--;
      end
      else if (!sclk_prev && sclk && cnt == 0)
         line <= 1'b1;
      sclk_prev <= sclk;
   end
endmodule : serial_peer_model

// ==== test_four_mode_serial_port.sv ====
// self-checking bench for the four-mode serial port
`timescale 1ns/1ns
module test_four_mode_serial_port;
   import serial_port_pkg::*;
   typedef struct {logic [11:0] ctl; logic [15:0] rel; logic [10:0] frm; int n; int t;
      logic [2:0] flg; logic [7:0] byt;} row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic data_out, data_oe, shift_clk_out, timer_irq, line, pv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] f;
   int err_count = 0, checks = 0, cyc = 0, t, i, last;
   // async transmit rows: mode 1, mode 2 with ninth bit, mode 2 double, mode 3
   row_s tx_rows[4] = '{'{12'h040, 16'hFFFE, 11'h34A, 10, 32, 3'h0, 8'h0},
      '{12'h088, 16'hFFFE, 11'h676, 11, 64, 3'h0, 8'h0},
      '{12'h280, 16'hFFFE, 11'h502, 11, 32, 3'h0, 8'h0},
      '{12'h0C8, 16'hFFFD, 11'h6BE, 11, 48, 3'h0, 8'h0}};
   // receive rows: store, held flag, qualify drop, qualify pass, disabled, mode 1
   row_s rx_rows[6] = '{'{12'h090, 16'hFFFE, 11'h4D8, 11, 64, 3'h1, 8'h6C},
      '{12'h091, 16'hFFFE, 11'h626, 11, 64, 3'h1, 8'h6C},
      '{12'h0B0, 16'hFFFE, 11'h488, 11, 64, 3'h0, 8'h6C},
      '{12'h0B0, 16'hFFFE, 11'h732, 11, 64, 3'h5, 8'h99},
      '{12'h080, 16'hFFFE, 11'h626, 11, 64, 3'h0, 8'h99},
      '{12'h450, 16'hFFFE, 11'h3CE, 10, 32, 3'h5, 8'hE7}};
   four_mode_serial_port #(.TIMER_PRESCALE(1)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(line),
      .data_out(data_out), .data_oe(data_oe), .shift_clk_out(shift_clk_out),
      .timer_irq(timer_irq));
   serial_peer_model peer (.pclk(pclk), .sclk(shift_clk_out), .line(line));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // hang guard, well above the expected run length
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_count++;
         finish_test();
      end
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (tx_rows[k])
      begin
         apb(1'b1, ADDR_RELOAD, {16'h0, tx_rows[k].rel});
         apb(1'b1, ADDR_CONTROL, {20'h0, tx_rows[k].ctl});
         apb(1'b1, ADDR_BUFFER, {24'h0, tx_rows[k].frm[8:1]});
         f = '0;
         while (data_out !== 1'b0) @(posedge pclk);
         for (t = 0; data_out === 1'b0; t++) @(posedge pclk);
         repeat (t / 2) @(posedge pclk);
         for (i = 1; i < tx_rows[k].n; i++)
         begin
            f[i] = data_out;
            repeat (t) @(posedge pclk);
         end
         check("tx frame", f, tx_rows[k].frm);
         check("bit time", t, tx_rows[k].t);
         apb(1'b0, ADDR_CONTROL, 32'h0);
         check("tx done", rd[CTL_TX_DONE], 1'b1);
         repeat (2 * t) @(posedge pclk);
         $display("tx row %0d finished", k);
      end
      // mode 0 transmit at both shift clock rates
      for (int s = 0; s < 2; s++)
      begin
         apb(1'b1, ADDR_CONTROL, s ? 32'h100 : 32'h0);
         apb(1'b1, ADDR_BUFFER, 32'hB1);
         i = 0;
         last = 0;
         pv = 1'b1;
         for (int k = 0; k < 400 && i < 8; k++)
         begin
            @(posedge pclk);
            if (shift_clk_out && !pv)
            begin
               f[i] = data_out;
               if (i > 0) check("shift period", k - last, s ? 2 : 12);
               last = k;
               i++;
            end
            pv = shift_clk_out;
         end
         check("sync byte", f[7:0], 8'hB1);
         apb(1'b0, ADDR_CONTROL, 32'h0);
         check("sync tx done", rd[CTL_TX_DONE], 1'b1);
      end
      // mode 0 receive, slow clock so the peer has a full phase to settle
      peer.load(8'hC6);
      apb(1'b1, ADDR_CONTROL, 32'h10);
      for (int k = 0; k < 60 && rd[CTL_RX_DONE] !== 1'b1; k++) apb(1'b0, ADDR_CONTROL, 32'h0);
      check("sync rx done", rd[CTL_RX_DONE], 1'b1);
      apb(1'b0, ADDR_BUFFER, 32'h0);
      check("sync rx byte", rd[7:0], 8'hC6);
      apb(1'b1, ADDR_CONTROL, 32'h0);
      $display("sync tests finished");
      foreach (rx_rows[k])
      begin
         apb(1'b1, ADDR_RELOAD, {16'h0, rx_rows[k].rel});
         apb(1'b1, ADDR_CONTROL, {20'h0, rx_rows[k].ctl});
         if (k == 0) peer.send(11'h0, 1, 20);
         repeat (100) @(posedge pclk);
         peer.send(rx_rows[k].frm, rx_rows[k].n, rx_rows[k].t);
         repeat (rx_rows[k].t) @(posedge pclk);
         apb(1'b0, ADDR_CONTROL, 32'h0);
         check("rx flags", rd & 32'h5, rx_rows[k].flg);
         apb(1'b0, ADDR_BUFFER, 32'h0);
         check("rx byte", rd[7:0], rx_rows[k].byt);
         check("irq", timer_irq, rx_rows[k].ctl[10]);
         $display("rx row %0d finished", k);
      end
      // reset in mid-frame, then an unmapped access
      apb(1'b1, ADDR_CONTROL, 32'h80);
      apb(1'b1, ADDR_BUFFER, 32'h0F);
      repeat (300) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check("idle line", data_out, 1'b1);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      check("control reset", rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped", rd | {31'h0, er}, 32'h1);
      $display("reset tests finished");
      finish_test();
   end
endmodule : test_four_mode_serial_port
